/* File: design/exec_unit_pkg.sv */
package exec_unit_pkg;
	typedef logic [29:0] word_t;
	typedef logic [14:0] half_t;
	typedef logic [59:0] pair_t;

	typedef struct packed {
		logic [5:0] func;
		logic [2:0] j;
		logic [2:0] k;
		logic [2:0] b;
		half_t y;
	} instr_t;

	typedef struct packed {
		logic strobe;
		logic [2:0] chan;
		word_t word;
	} ext_func_t;

	typedef struct packed {
		logic strobe;
		logic [2:0] chan;
	} chan_ack_t;

	// apb register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_MEM = 8'h04;
	localparam logic [7:0] OFS_ACC = 8'h08;
	localparam logic [7:0] OFS_AUX = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_STORE_DATA = 8'h14;
	localparam logic [7:0] OFS_STORE_ADDR = 8'h18;
	localparam logic [7:0] OFS_INDEX_BASE = 8'h20;

	// status bit positions
	localparam int ST_SKIP = 0;
	localparam int ST_DIV_FAULT = 1;
	localparam int ST_STORE = 2;
	localparam int ST_ILLEGAL = 3;

	localparam word_t WORD_RST = 30'h0;
	localparam half_t HALF_RST = 15'h0;
	localparam logic [5:0] ROT_W = 6'h1e;

	// function codes
	localparam logic [5:0] FN_RSH_AUX = 6'h01;
	localparam logic [5:0] FN_RSH_ACC = 6'h02;
	localparam logic [5:0] FN_RSH_PAIR = 6'h03;
	localparam logic [5:0] FN_COMPARE = 6'h04;
	localparam logic [5:0] FN_LSH_AUX = 6'h05;
	localparam logic [5:0] FN_LSH_ACC = 6'h06;
	localparam logic [5:0] FN_LSH_PAIR = 6'h07;
	localparam logic [5:0] FN_ENTER_AUX = 6'h08;
	localparam logic [5:0] FN_ENTER_ACC = 6'h09;
	localparam logic [5:0] FN_ENTER_IDX = 6'h0a;
	localparam logic [5:0] FN_EXT_FUNC = 6'h0b;
	localparam logic [5:0] FN_STORE_AUX = 6'h0c;
	localparam logic [5:0] FN_STORE_ACC = 6'h0d;
	localparam logic [5:0] FN_STORE_IDX = 6'h0e;
	localparam logic [5:0] FN_STORE_CHAN = 6'h0f;
	localparam logic [5:0] FN_ADD = 6'h10;
	localparam logic [5:0] FN_SUB = 6'h11;
	localparam logic [5:0] FN_MUL = 6'h12;
	localparam logic [5:0] FN_DIV = 6'h13;
	localparam logic [5:0] FN_REPL_ADD = 6'h14;
	localparam logic [5:0] FN_REPL_SUB = 6'h15;

	// operand interpretation modes
	localparam logic [2:0] K_ADDR = 3'h0;
	localparam logic [2:0] K_LOW = 3'h1;
	localparam logic [2:0] K_UP = 3'h2;
	localparam logic [2:0] K_FULL = 3'h3;
	localparam logic [2:0] K_ADDR_SX = 3'h4;
	localparam logic [2:0] K_LOW_SX = 3'h5;
	localparam logic [2:0] K_UP_SX = 3'h6;
	localparam logic [2:0] K_ACC = 3'h7;
endpackage

/* File: design/exec_unit.sv */
// Overview of operation
// [RULE_01] right shifts of aux or acc fill vacated high bits with the sign
// [RULE_02] shift count comes only from the low six operand bits
// [RULE_03] double right shift treats acc and aux as one 60-bit value
// [RULE_04] left shifts of aux or acc rotate circularly by the count
// [RULE_05] double left shift rotates the 60-bit pair circularly
// [RULE_06] software never asks for a rotate count above fifty-nine
// [RULE_07] compare leaves acc and aux unchanged
// [RULE_08] compare branch field picks one of eight skip conditions
// [RULE_09] enter aux or acc loads the full operand
// [RULE_10] enter index loads low 15 operand bits into index j, no skip
// [RULE_11] external function on channel 0 or 1 skips if partner input active
// [RULE_12] other channels send the operand as function word, mode 3 only
// [RULE_13] store aux: mode 0 complements aux, mode 4 copies to acc
// [RULE_14] store acc: mode 4 complements acc, mode 0 copies to aux
// [RULE_15] store index writes the index in low half, upper half zero
// [RULE_16] store channel writes channel word then acknowledges, mode 3 only; code raises the acknowledge in the same cycle as the store
// [RULE_17] add and subtract update the accumulator
// [RULE_18] multiply aux by operand into the double-length pair
// [RULE_19] multiply with branch code 4 skips when final acc is zero
// [RULE_20] divide pair by operand, quotient to aux, remainder to acc
// [RULE_21] divide fault skips on code 3, correct quotient skips on code 2
// [RULE_22] replace add and subtract write acc back to the operand address
// [RULE_23] mode field chooses the operand; mode 7 takes the accumulator
// [RULE_24] index field adds an index to the address, one's complement 15-bit
// [RULE_25] all arithmetic is 30-bit one's complement, sign in bit 29
//
// The address map and the APB slave port were decided locally.
module exec_unit (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] partner_input_active,
	input wire exec_unit_pkg::word_t chan_in_word,
	output exec_unit_pkg::ext_func_t ext_func,
	output exec_unit_pkg::chan_ack_t input_ack
);

	////////////////////////////////////////////////////////////////////////
	// one's complement helpers

	function automatic exec_unit_pkg::word_t oc_add(input exec_unit_pkg::word_t a, input exec_unit_pkg::word_t b);
		logic [30:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[29:0] + {29'h0, s[30]};
	endfunction

	function automatic exec_unit_pkg::half_t oc_add15(input exec_unit_pkg::half_t a, input exec_unit_pkg::half_t b);
		logic [15:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[14:0] + {14'h0, s[15]};
	endfunction

	function automatic exec_unit_pkg::word_t oc_mag(input exec_unit_pkg::word_t x);
		return x[29] ? ~x : x;
	endfunction

	function automatic logic signed [30:0] oc_val(input exec_unit_pkg::word_t x);
		logic signed [30:0] m;
		m = $signed({1'b0, oc_mag(x)});
		return x[29] ? -m : m;
	endfunction

	function automatic exec_unit_pkg::word_t rotl30(input exec_unit_pkg::word_t x, input logic [5:0] n);
		logic [59:0] r;
		logic [5:0] m;
		m = 6'(n % exec_unit_pkg::ROT_W);
		r = {x, x} << m;
		return r[59:30];
	endfunction

	function automatic exec_unit_pkg::word_t store_fmt(input logic [2:0] k, input exec_unit_pkg::word_t src,
			input exec_unit_pkg::word_t mem);
		case (k)
			exec_unit_pkg::K_LOW: return {mem[29:15], src[14:0]};
			exec_unit_pkg::K_UP: return {src[14:0], mem[14:0]};
			exec_unit_pkg::K_LOW_SX: return {mem[29:15], ~src[14:0]};
			exec_unit_pkg::K_UP_SX: return {~src[14:0], mem[14:0]};
			exec_unit_pkg::K_ACC: return ~src;
			default: return src;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers

	exec_unit_pkg::word_t acc_r, acc_nxt;
	exec_unit_pkg::word_t aux_r, aux_nxt;
	exec_unit_pkg::word_t mem_word_r;
	exec_unit_pkg::word_t store_data_r, store_data_nxt;
	exec_unit_pkg::half_t store_addr_r;
	exec_unit_pkg::half_t idx_r [1:7];
	logic skip_r, skip_nxt;
	logic div_fault_r, div_fault_nxt;
	logic store_r, store_nxt;
	logic illegal_r, illegal_nxt;
	logic idx_we;
	exec_unit_pkg::half_t idx_wval;
	logic [1:0] act_s1_r, act_s2_r;
	exec_unit_pkg::word_t chan_s1_r, chan_s2_r;
	exec_unit_pkg::ext_func_t ext_func_nxt;
	exec_unit_pkg::chan_ack_t input_ack_nxt;

	////////////////////////////////////////////////////////////////////////
	// apb slave: pready rises one cycle into the access phase

	wire logic access = psel & penable;
	wire logic commit = access & pready;
	wire logic idx_hit = (paddr[7:5] == exec_unit_pkg::OFS_INDEX_BASE[7:5]) && (paddr[1:0] == 2'h0);
	wire logic [2:0] idx_ofs = paddr[4:2];
	wire logic addr_hit = idx_hit || (paddr == exec_unit_pkg::OFS_INSTR) || (paddr == exec_unit_pkg::OFS_MEM) ||
		(paddr == exec_unit_pkg::OFS_ACC) || (paddr == exec_unit_pkg::OFS_AUX) ||
		(paddr == exec_unit_pkg::OFS_STATUS) || (paddr == exec_unit_pkg::OFS_STORE_DATA) ||
		(paddr == exec_unit_pkg::OFS_STORE_ADDR);
	wire logic wr_ok = commit & pwrite & addr_hit;
	wire logic exec_fire = wr_ok && (paddr == exec_unit_pkg::OFS_INSTR);
	wire logic [31:0] status_word = {28'h0, illegal_r, store_r, div_fault_r, skip_r};
	wire exec_unit_pkg::half_t idx_rd = (idx_ofs == 3'h0) ? exec_unit_pkg::HALF_RST : idx_r[idx_ofs];
	wire logic [31:0] rd_mux =
		idx_hit ? {17'h0, idx_rd} :
		(paddr == exec_unit_pkg::OFS_MEM) ? {2'h0, mem_word_r} :
		(paddr == exec_unit_pkg::OFS_ACC) ? {2'h0, acc_r} :
		(paddr == exec_unit_pkg::OFS_AUX) ? {2'h0, aux_r} :
		(paddr == exec_unit_pkg::OFS_STATUS) ? status_word :
		(paddr == exec_unit_pkg::OFS_STORE_DATA) ? {2'h0, store_data_r} :
		(paddr == exec_unit_pkg::OFS_STORE_ADDR) ? {17'h0, store_addr_r} : 32'h0;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			prdata <= (access & ~pready & ~pwrite) ? rd_mux : 32'h0;
			pslverr <= access & ~pready & ~addr_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_s1_r <= 2'h0;
			act_s2_r <= 2'h0;
			chan_s1_r <= exec_unit_pkg::WORD_RST;
			chan_s2_r <= exec_unit_pkg::WORD_RST;
		end else begin
			act_s1_r <= partner_input_active;
			act_s2_r <= act_s1_r;
			chan_s1_r <= chan_in_word;
			chan_s2_r <= chan_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// instruction decode and operand formation

	wire exec_unit_pkg::instr_t ins = pwdata[29:0];
	wire exec_unit_pkg::half_t idx_sel = (ins.b == 3'h0) ? exec_unit_pkg::HALF_RST : idx_r[ins.b];
	wire exec_unit_pkg::half_t addr_eff = oc_add15(ins.y, idx_sel); // RULE_24
	wire exec_unit_pkg::half_t idx_j = (ins.j == 3'h0) ? exec_unit_pkg::HALF_RST : idx_r[ins.j];
	exec_unit_pkg::word_t opnd;

	always_comb begin // RULE_23
		case (ins.k)
			exec_unit_pkg::K_ADDR: opnd = {15'h0, addr_eff};
			exec_unit_pkg::K_LOW: opnd = {15'h0, mem_word_r[14:0]};
			exec_unit_pkg::K_UP: opnd = {15'h0, mem_word_r[29:15]};
			exec_unit_pkg::K_FULL: opnd = mem_word_r;
			exec_unit_pkg::K_ADDR_SX: opnd = {{15{addr_eff[14]}}, addr_eff};
			exec_unit_pkg::K_LOW_SX: opnd = {{15{mem_word_r[14]}}, mem_word_r[14:0]};
			exec_unit_pkg::K_UP_SX: opnd = {{15{mem_word_r[29]}}, mem_word_r[29:15]};
			default: opnd = acc_r;
		endcase
	end

	wire logic [5:0] shift_cnt = opnd[5:0]; // RULE_02
	wire exec_unit_pkg::pair_t pair_cur = {acc_r, aux_r}; // RULE_03
	wire exec_unit_pkg::pair_t pair_rsh = exec_unit_pkg::pair_t'($signed(pair_cur) >>> shift_cnt); // RULE_03
	wire logic [119:0] pair_dbl = {pair_cur, pair_cur} << shift_cnt; // RULE_05 RULE_06
	wire exec_unit_pkg::pair_t pair_rol = pair_dbl[119:60]; // RULE_05
	wire logic signed [30:0] v_op = oc_val(opnd); // RULE_25
	wire logic signed [30:0] v_aux = oc_val(aux_r);
	wire logic signed [30:0] v_acc = oc_val(acc_r);
	wire exec_unit_pkg::word_t sum_add = oc_add(acc_r, opnd); // RULE_17
	wire exec_unit_pkg::word_t sum_sub = oc_add(acc_r, ~opnd); // RULE_17 RULE_25

	// multiply on magnitudes, sign applied as a 60-bit complement
	wire exec_unit_pkg::pair_t prod_mag = {30'h0, oc_mag(aux_r)} * {30'h0, oc_mag(opnd)}; // RULE_18
	wire logic prod_neg = aux_r[29] ^ opnd[29];
	wire exec_unit_pkg::pair_t prod = prod_neg ? ~prod_mag : prod_mag; // RULE_18

	// divide: fault on zero divisor or quotient beyond 29 magnitude bits
	wire logic dvd_neg = acc_r[29];
	wire exec_unit_pkg::pair_t dvd_mag = dvd_neg ? ~pair_cur : pair_cur;
	wire exec_unit_pkg::pair_t dvs_mag = {30'h0, oc_mag(opnd)};
	wire logic dvs_zero = (dvs_mag == 60'h0);
	wire exec_unit_pkg::pair_t quot = dvs_zero ? 60'h0 : dvd_mag / dvs_mag; // RULE_20
	wire exec_unit_pkg::pair_t rem = dvs_zero ? 60'h0 : dvd_mag % dvs_mag; // RULE_20
	wire logic div_bad = dvs_zero || (quot[59:29] != 31'h0); // RULE_21
	wire logic quot_neg = dvd_neg ^ opnd[29];

	////////////////////////////////////////////////////////////////////////
	// execution

	always_comb begin
		acc_nxt = acc_r;
		aux_nxt = aux_r;
		skip_nxt = skip_r;
		div_fault_nxt = div_fault_r;
		store_nxt = store_r;
		illegal_nxt = illegal_r;
		store_data_nxt = store_data_r;
		idx_we = 1'b0;
		idx_wval = opnd[14:0];
		ext_func_nxt = '{strobe: 1'b0, chan: ext_func.chan, word: ext_func.word};
		input_ack_nxt = '{strobe: 1'b0, chan: input_ack.chan};
		if (exec_fire) begin
			skip_nxt = 1'b0;
			div_fault_nxt = 1'b0;
			store_nxt = 1'b0;
			illegal_nxt = 1'b0;
			case (ins.func)
				exec_unit_pkg::FN_RSH_AUX: aux_nxt = exec_unit_pkg::word_t'($signed(aux_r) >>> shift_cnt); // RULE_01
				exec_unit_pkg::FN_RSH_ACC: acc_nxt = exec_unit_pkg::word_t'($signed(acc_r) >>> shift_cnt); // RULE_01
				exec_unit_pkg::FN_RSH_PAIR: {acc_nxt, aux_nxt} = pair_rsh; // RULE_03
				exec_unit_pkg::FN_LSH_AUX: aux_nxt = rotl30(aux_r, shift_cnt); // RULE_04
				exec_unit_pkg::FN_LSH_ACC: acc_nxt = rotl30(acc_r, shift_cnt); // RULE_04
				exec_unit_pkg::FN_LSH_PAIR: {acc_nxt, aux_nxt} = pair_rol; // RULE_05
				exec_unit_pkg::FN_COMPARE: begin // RULE_07
					case (ins.j) // RULE_08
						3'h0: skip_nxt = 1'b0;
						3'h1: skip_nxt = 1'b1;
						3'h2: skip_nxt = (v_op <= v_aux);
						3'h3: skip_nxt = (v_op > v_aux);
						3'h4: skip_nxt = (v_aux >= v_op) && (v_op > v_acc);
						3'h5: skip_nxt = (v_op > v_aux) || (v_op <= v_acc);
						3'h6: skip_nxt = (v_op <= v_acc);
						default: skip_nxt = (v_op > v_acc);
					endcase
				end
				exec_unit_pkg::FN_ENTER_AUX: aux_nxt = opnd; // RULE_09
				exec_unit_pkg::FN_ENTER_ACC: acc_nxt = opnd; // RULE_09
				exec_unit_pkg::FN_ENTER_IDX: idx_we = (ins.j != 3'h0); // RULE_10
				exec_unit_pkg::FN_EXT_FUNC: begin
					if (ins.k != exec_unit_pkg::K_FULL) begin
						illegal_nxt = 1'b1; // RULE_12
					end else if (ins.j[2:1] == 2'h0) begin
						skip_nxt = act_s2_r[ins.j[0]]; // RULE_11
					end else begin
						ext_func_nxt = '{strobe: 1'b1, chan: ins.j, word: opnd}; // RULE_12
					end
				end
				exec_unit_pkg::FN_STORE_AUX: begin
					if (ins.k == exec_unit_pkg::K_ADDR) begin
						aux_nxt = ~aux_r; // RULE_13
					end else if (ins.k == exec_unit_pkg::K_ADDR_SX) begin
						acc_nxt = aux_r; // RULE_13
					end else begin
						store_nxt = 1'b1;
						store_data_nxt = store_fmt(ins.k, aux_r, mem_word_r);
					end
				end
				exec_unit_pkg::FN_STORE_ACC: begin
					if (ins.k == exec_unit_pkg::K_ADDR_SX) begin
						acc_nxt = ~acc_r; // RULE_14
					end else if (ins.k == exec_unit_pkg::K_ADDR) begin
						aux_nxt = acc_r; // RULE_14
					end else begin
						store_nxt = 1'b1;
						store_data_nxt = store_fmt(ins.k, acc_r, mem_word_r);
					end
				end
				exec_unit_pkg::FN_STORE_IDX: begin
					store_nxt = 1'b1;
					store_data_nxt = {15'h0, idx_j}; // RULE_15
				end
				exec_unit_pkg::FN_STORE_CHAN: begin
					if (ins.k != exec_unit_pkg::K_FULL) begin
						illegal_nxt = 1'b1; // RULE_16
					end else begin
						store_nxt = 1'b1;
						store_data_nxt = chan_s2_r; // RULE_16
						input_ack_nxt = '{strobe: 1'b1, chan: ins.j}; // RULE_16
					end
				end
				exec_unit_pkg::FN_ADD: acc_nxt = sum_add; // RULE_17
				exec_unit_pkg::FN_SUB: acc_nxt = sum_sub; // RULE_17
				exec_unit_pkg::FN_MUL: begin
					{acc_nxt, aux_nxt} = prod; // RULE_18
					skip_nxt = (ins.j == 3'h4) && (prod[59:30] == exec_unit_pkg::WORD_RST); // RULE_19
				end
				exec_unit_pkg::FN_DIV: begin
					div_fault_nxt = div_bad; // RULE_21
					skip_nxt = ((ins.j == 3'h3) && div_bad) || ((ins.j == 3'h2) && !div_bad); // RULE_21
					if (!div_bad) begin
						aux_nxt = quot_neg ? ~quot[29:0] : quot[29:0]; // RULE_20
						acc_nxt = quot_neg ? ~rem[29:0] : rem[29:0]; // RULE_20
					end
				end
				exec_unit_pkg::FN_REPL_ADD, exec_unit_pkg::FN_REPL_SUB: begin
					acc_nxt = (ins.func == exec_unit_pkg::FN_REPL_ADD) ? sum_add : sum_sub; // RULE_22
					store_nxt = 1'b1;
					store_data_nxt = store_fmt(ins.k, acc_nxt, mem_word_r); // RULE_22
				end
				default: illegal_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= exec_unit_pkg::WORD_RST;
			aux_r <= exec_unit_pkg::WORD_RST;
			mem_word_r <= exec_unit_pkg::WORD_RST;
			store_data_r <= exec_unit_pkg::WORD_RST;
			store_addr_r <= exec_unit_pkg::HALF_RST;
			skip_r <= 1'b0;
			div_fault_r <= 1'b0;
			store_r <= 1'b0;
			illegal_r <= 1'b0;
			ext_func <= '0;
			input_ack <= '0;
		end else begin
			acc_r <= (wr_ok && paddr == exec_unit_pkg::OFS_ACC) ? pwdata[29:0] : acc_nxt;
			aux_r <= (wr_ok && paddr == exec_unit_pkg::OFS_AUX) ? pwdata[29:0] : aux_nxt;
			mem_word_r <= (wr_ok && paddr == exec_unit_pkg::OFS_MEM) ? pwdata[29:0] : mem_word_r;
			store_data_r <= store_data_nxt;
			store_addr_r <= (exec_fire && store_nxt) ? addr_eff : store_addr_r;
			skip_r <= skip_nxt;
			div_fault_r <= div_fault_nxt;
			store_r <= store_nxt;
			illegal_r <= illegal_nxt;
			ext_func <= ext_func_nxt;
			input_ack <= input_ack_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 1; i <= 7; i++) begin
				idx_r[i] <= exec_unit_pkg::HALF_RST;
			end
		end else begin
			for (int i = 1; i <= 7; i++) begin
				if (idx_we && ins.j == 3'(i)) begin
					idx_r[i] <= idx_wval; // RULE_10
				end else if (wr_ok && idx_hit && idx_ofs == 3'(i)) begin
					idx_r[i] <= pwdata[14:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	AST_RSH_AUX: assert property (exec_fire && ins.func == exec_unit_pkg::FN_RSH_AUX // RULE_01
		&& ins.k == exec_unit_pkg::K_FULL |=>
		aux_r == exec_unit_pkg::word_t'($signed($past(aux_r)) >>> $past(mem_word_r[5:0])))
		else $error("right shift of aux wrong");
	AST_RSH_PAIR_SIGN: assert property (exec_fire && ins.func == exec_unit_pkg::FN_RSH_PAIR // RULE_03
		&& ins.k == exec_unit_pkg::K_FULL && mem_word_r[5:0] == 6'h01 |=>
		acc_r[29] == $past(acc_r[29]) && aux_r[29] == $past(acc_r[0]))
		else $error("double right shift lost sign or carry");
	AST_ROT_ACC: assert property (exec_fire && ins.func == exec_unit_pkg::FN_LSH_ACC // RULE_04
		&& ins.k == exec_unit_pkg::K_FULL && mem_word_r[29:6] != 24'h0 && mem_word_r[5:0] == 6'h01 |=>
		acc_r == {$past(acc_r[28:0]), $past(acc_r[29])})
		else $error("rotate ignored count bits wrongly");
	AST_CMP_KEEP: assert property (exec_fire && ins.func == exec_unit_pkg::FN_COMPARE |=> // RULE_07
		$stable(acc_r) && $stable(aux_r))
		else $error("compare altered a register");
	AST_CMP_ALWAYS: assert property (exec_fire && ins.func == exec_unit_pkg::FN_COMPARE && ins.j == 3'h1 // RULE_08
		|=> skip_r ##1 (skip_r || $past(exec_fire)))
		else $error("compare code 1 did not skip");
	AST_EXT_PULSE: assert property (exec_fire && ins.func == exec_unit_pkg::FN_EXT_FUNC // RULE_12
		&& ins.k == exec_unit_pkg::K_FULL && ins.j[2:1] != 2'h0 |=> ext_func.strobe ##1 !ext_func.strobe)
		else $error("function word strobe not one cycle");
	AST_ACK: assert property (exec_fire && ins.func == exec_unit_pkg::FN_STORE_CHAN // RULE_16
		&& ins.k == exec_unit_pkg::K_FULL |=> input_ack.strobe && store_r && store_data_r == $past(chan_s2_r))
		else $error("channel store or acknowledge missing");
	AST_IDX_STORE: assert property (exec_fire && ins.func == exec_unit_pkg::FN_STORE_IDX |=> // RULE_15
		store_data_r[29:15] == 15'h0 && store_r)
		else $error("index store upper half not zero");
	AST_DIV_ZERO: assert property (exec_fire && ins.func == exec_unit_pkg::FN_DIV && dvs_zero // RULE_21
		&& ins.j == 3'h3 |=> skip_r && div_fault_r && $stable(aux_r))
		else $error("divide fault not sensed");
	AST_APB_WAIT: assert property (access && !pready |=> pready ##1 !pready)
		else $error("apb answer timing broken");

endmodule // exec_unit

/* File: verif/chan_partner.sv */
// far side of the channel pins: holds the input flags and word, logs every strobe
module chan_partner (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] act_cfg,
	input wire exec_unit_pkg::word_t word_cfg,
	input wire exec_unit_pkg::ext_func_t ext_func,
	input wire exec_unit_pkg::chan_ack_t input_ack,
	output logic [1:0] partner_input_active,
	output exec_unit_pkg::word_t chan_in_word,
	output int fn_cnt,
	output int ack_cnt,
	output exec_unit_pkg::ext_func_t fn_last,
	output logic [2:0] ack_chan
);
	timeunit 1ns;
	timeprecision 1ps;
	assign partner_input_active = act_cfg;
	assign chan_in_word = word_cfg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fn_cnt <= 0;
			ack_cnt <= 0;
			fn_last <= '0;
			ack_chan <= 3'h0;
		end else begin
			if (ext_func.strobe === 1'b1) begin
				fn_cnt <= fn_cnt + 1;
				fn_last <= ext_func;
			end
			if (input_ack.strobe === 1'b1) begin
				ack_cnt <= ack_cnt + 1;
				ack_chan <= input_ack.chan;
			end
		end
	end
endmodule // chan_partner

/* File: verif/shift_compare_load_store_arith_unit_bench.sv */
module shift_compare_load_store_arith_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [1:0] act_cfg, pia;
	logic [2:0] ack_chan, j;
	logic [5:0] f;
	logic [7:0] cv;
	logic [15:0] s16;
	exec_unit_pkg::word_t ciw, word_cfg, a, q, m;
	exec_unit_pkg::ext_func_t ext_func, fn_last;
	exec_unit_pkg::chan_ack_t input_ack;
	int fn_cnt, ack_cnt, errors, checked, c, yi, ai, qi;
	longint p;
	integer seed;
	exec_unit dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.partner_input_active(pia), .chan_in_word(ciw), .ext_func(ext_func), .input_ack(input_ack));
	chan_partner partner (.core_clk(core_clk), .rst_n(rst_n), .act_cfg(act_cfg), .word_cfg(word_cfg),
		.ext_func(ext_func), .input_ack(input_ack), .partner_input_active(pia), .chan_in_word(ciw),
		.fn_cnt(fn_cnt), .ack_cnt(ack_cnt), .fn_last(fn_last), .ack_chan(ack_chan));
	////////////////////////////////////////////////////////////////
	function automatic logic [29:0] oadd(logic [29:0] x, logic [29:0] y);
		logic [30:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[29:0] + 30'(s[30]);
	endfunction
	function automatic int sv(logic [29:0] x);
		return x[29] ? -int'(~x) : int'(x);
	endfunction
	function automatic logic [29:0] rot(logic [29:0] x, int n);
		logic [59:0] t;
		t = {x, x} << n;
		return t[59:30];
	endfunction
	function automatic logic [59:0] rotp(logic [59:0] x, int n);
		logic [119:0] t;
		t = {x, x} << n;
		return t[119:60];
	endfunction
	task results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// apb master: setup, access, hold until pready is sampled high
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task setr;
		apb(1'b1, exec_unit_pkg::OFS_ACC, {2'b00, a});
		apb(1'b1, exec_unit_pkg::OFS_AUX, {2'b00, q});
		apb(1'b1, exec_unit_pkg::OFS_MEM, {2'b00, m});
	endtask
	task run(input logic [5:0] fn, input logic [2:0] jj, input logic [2:0] kk, input logic [2:0] bb, input logic [14:0] y);
		apb(1'b1, exec_unit_pkg::OFS_INSTR, {2'b00, fn, jj, kk, bb, y});
	endtask
	task regs;
		apb(1'b0, exec_unit_pkg::OFS_ACC, 32'h0);
		chk(rv, {2'b00, a});
		apb(1'b0, exec_unit_pkg::OFS_AUX, 32'h0);
		chk(rv, {2'b00, q});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		chk(32'h1, 32'h0);
		results();
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, act_cfg, word_cfg, a, q} = '0;
		seed = 32'hed8d9cd1;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		regs();
		for (int i = 0; i < 6; i++) begin
			f = (i < 3) ? 6'(i + 1) : 6'(i + 2);
			a = 30'($random(seed));
			q = 30'($random(seed));
			m = 30'($random(seed));
			m[5:0] = (i == 2 || i == 4) ? 6'h01 : m[5:0] % 60;
			setr();
			run(f, 3'h0, exec_unit_pkg::K_FULL, 3'h0, 15'h0);
			case (i)
				0: q = $signed(q) >>> m[5:0];
				1: a = $signed(a) >>> m[5:0];
				2: {a, q} = $signed({a, q}) >>> m[5:0];
				3: q = rot(q, m[5:0] % 30);
				4: a = rot(a, m[5:0] % 30);
				default: {a, q} = rotp({a, q}, m[5:0]);
			endcase
			regs();
		end
		$display("shift test done");
		for (int i = 0; i < 8; i++) begin
			a = 30'($random(seed));
			q = 30'($random(seed));
			m = (i > 3) ? a ^ 30'($random(seed) & 3) : 30'($random(seed));
			setr();
			run(exec_unit_pkg::FN_COMPARE, 3'(i), exec_unit_pkg::K_FULL, 3'h0, 15'h0);
			yi = sv(m);
			ai = sv(a);
			qi = sv(q);
			cv = {yi > ai, yi <= ai, yi > qi || yi <= ai, qi >= yi && yi > ai, yi > qi, yi <= qi, 1'b1, 1'b0};
			apb(1'b0, exec_unit_pkg::OFS_STATUS, 32'h0);
			chk(rv[0], cv[i]);
			regs();
		end
		$display("compare test done");
		j = 3'({$random(seed)} % 7 + 1);
		m = 30'($random(seed));
		setr();
		run(exec_unit_pkg::FN_ENTER_IDX, j, exec_unit_pkg::K_FULL, 3'h0, 15'h0);
		apb(1'b0, exec_unit_pkg::OFS_INDEX_BASE + 8'(4 * j), 32'h0);
		chk(rv, {17'h0, m[14:0]});
		run(exec_unit_pkg::FN_STORE_IDX, j, exec_unit_pkg::K_FULL, 3'h0, 15'h0);
		apb(1'b0, exec_unit_pkg::OFS_STORE_DATA, 32'h0);
		chk(rv, {17'h0, m[14:0]});
		f = 6'($random(seed));
		s16 = {1'b0, 6'h0, f, 3'h1} + {1'b0, m[14:0]};
		run(exec_unit_pkg::FN_ENTER_ACC, 3'h0, exec_unit_pkg::K_ADDR, j, {6'h0, f, 3'h1});
		a = {15'h0, s16[14:0] + 15'(s16[15])};
		m = 30'($random(seed));
		apb(1'b1, exec_unit_pkg::OFS_MEM, {2'b00, m});
		for (int k = 1; k < 8; k++) begin
			run(exec_unit_pkg::FN_ENTER_AUX, 3'h0, 3'(k), 3'h0, 15'h0);
			q = k[1] ? {{15{k[2] & m[29]}}, m[29:15]} : {{15{k[2] & m[14]}}, m[14:0]};
			q = (k == 3) ? m : (k == 4) ? 30'h0 : (k == 7) ? a : q;
			regs();
		end
		for (int i = 0; i < 4; i++) begin
			m = 30'($random(seed));
			apb(1'b1, exec_unit_pkg::OFS_MEM, {2'b00, m});
			run(6'(i == 3 ? 21 : i + 16), 3'h0, exec_unit_pkg::K_FULL, 3'h0, 15'h0);
			a = (i == 1 || i == 3) ? oadd(a, ~m) : (i == 2 ? a : oadd(a, m));
			p = longint'(sv(q)) * sv(m);
			if (i == 2) {a, q} = (p < 0) ? ~60'(-p) : 60'(p);
			regs();
			if (i == 3) apb(1'b0, exec_unit_pkg::OFS_STORE_DATA, 32'h0);
			if (i == 3) chk(rv, {2'b00, a});
		end
		m = 30'($random(seed)) & 30'h3fff;
		q = 30'($random(seed)) & 30'hfffff;
		setr();
		for (int i = 0; i < 4; i++) begin
			run(i[0] ? exec_unit_pkg::FN_STORE_ACC : exec_unit_pkg::FN_STORE_AUX, 3'h0, i[1] ? 3'h4 : 3'h0, 3'h0, 15'h0);
			case (i)
				0: q = ~q;
				1: q = a;
				2: a = q;
				default: a = ~a;
			endcase
			regs();
		end
		a = 30'h0;
		q = 30'($random(seed)) & 30'hfffff;
		m = m | 30'h1;
		setr();
		run(exec_unit_pkg::FN_DIV, 3'h2, exec_unit_pkg::K_FULL, 3'h0, 15'h0);
		apb(1'b0, exec_unit_pkg::OFS_STATUS, 32'h0);
		chk(rv[1:0], 2'b01);
		a = 30'(q % m);
		q = 30'(q / m);
		regs();
		m = 30'h0;
		setr();
		run(exec_unit_pkg::FN_DIV, 3'h3, exec_unit_pkg::K_FULL, 3'h0, 15'h0);
		apb(1'b0, exec_unit_pkg::OFS_STATUS, 32'h0);
		chk(rv[1:0], 2'b11);
		$display("arithmetic test done");
		act_cfg <= 2'($random(seed));
		word_cfg <= 30'($random(seed));
		for (int i = 0; i < 8; i++) begin
			m = 30'($random(seed));
			c = fn_cnt;
			apb(1'b1, exec_unit_pkg::OFS_MEM, {2'b00, m});
			run(exec_unit_pkg::FN_EXT_FUNC, 3'(i), exec_unit_pkg::K_FULL, 3'h0, 15'h0);
			apb(1'b0, exec_unit_pkg::OFS_STATUS, 32'h0);
			if (i < 2) chk(rv[0], act_cfg[i]);
			if (i > 1) chk({fn_last.chan, 29'(fn_cnt - c)}, {3'(i), 29'h1});
			if (i > 1) chk(fn_last.word, m);
		end
		c = fn_cnt;
		run(exec_unit_pkg::FN_EXT_FUNC, 3'h2, exec_unit_pkg::K_ADDR, 3'h0, 15'h0);
		apb(1'b0, exec_unit_pkg::OFS_STATUS, 32'h0);
		chk({29'(fn_cnt - c), rv[3]}, {29'h0, 1'b1});
		run(exec_unit_pkg::FN_STORE_CHAN, 3'h5, exec_unit_pkg::K_FULL, 3'h0, 15'h0);
		apb(1'b0, exec_unit_pkg::OFS_STORE_DATA, 32'h0);
		chk({ack_chan, 29'(ack_cnt)}, {3'h5, 29'h1});
		chk(rv, {2'b00, word_cfg});
		apb(1'b0, 8'h40, 32'h0);
		chk(rv, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("channel test done");
		results();
	end
endmodule // shift_compare_load_store_arith_unit_bench
